// ### ssp_pkg.sv
// package: register map, field layout and encodings of the sync serial port
package ssp_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] OFS_BUF  = 4'h0;  // port_data_buffer
   localparam logic [3:0] OFS_CTRL = 4'h4;  // port control
   localparam logic [3:0] OFS_STAT = 4'h8;  // port status
   localparam logic [3:0] OFS_ADDR = 4'hC;  // own bus address
   // ---------------------------------------------------------------
   // control fields
   // ---------------------------------------------------------------
   localparam int CTRL_EN   = 0;            // port_enable_bit
   localparam int CTRL_MODE = 1;            // mode field, two bits
   localparam int CTRL_IE   = 3;            // port irq enable
   localparam logic [7:0] CTRL_RST = 8'h00; // control reset value
   localparam logic [6:0] ADDR_RST = 7'h2A; // own address reset value
   // ---------------------------------------------------------------
   // status fields
   // ---------------------------------------------------------------
   localparam int ST_BF   = 0;              // buffer_full_flag
   localparam int ST_IF   = 1;              // port_irq_flag
   localparam int ST_WCOL = 2;              // write collision
   localparam int ST_ARB  = 3;              // arbitration lost
   localparam int ST_RW   = 4;              // direction of last address
   localparam int ST_OVF  = 5;              // receive overflow
   localparam int ST_BUSY = 6;              // transfer in progress
   // ---------------------------------------------------------------
   // timing and sizes
   // ---------------------------------------------------------------
   localparam logic [7:0] SPI_HALF_CYC = 8'h04; // master clock half period
   localparam logic [3:0] BYTE_BITS    = 4'h8;  // bits per byte
   // ---------------------------------------------------------------
   // encodings
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_SPI_MST = 2'h0,
      MODE_SPI_SLV = 2'h1,
      MODE_I2C_SLV = 2'h2,
      MODE_OFF     = 2'h3
   } ssp_mode_type;
   typedef enum logic [2:0] {
      I2C_IDLE = 3'h0,
      I2C_ADDR = 3'h1,
      I2C_ACK  = 3'h3,
      I2C_RX   = 3'h2,
      I2C_STR  = 3'h6,
      I2C_TX   = 3'h7,
      I2C_TACK = 3'h5
   } ssp_i2c_type;
endpackage

// ### ssp_port.sv
// module: sync serial port with spi master/slave and two-wire slave
`timescale 1ns/1ps
module ssp_port #(
   parameter logic [7:0] SPI_DIV = ssp_pkg::SPI_HALF_CYC
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // avalon-mm slave
   input  wire logic [3:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   output logic [31:0]      readdata_o,
   output logic             waitrequest_o,
   // power state
   input  wire logic        sleep_i,
   // spi pins
   input  wire logic        serial_clock_pin_i,
   output logic             serial_clock_pin_o,
   output logic             serial_clock_pin_oe_o,
   input  wire logic        sdi_i,
   output logic             sdo_o,
   // two-wire bus pins
   input  wire logic        bus_clock_line_i,
   output logic             bus_clock_line_o,
   output logic             bus_clock_line_oe_o,
   input  wire logic        bus_data_line_i,
   output logic             bus_data_line_o,
   output logic             bus_data_line_oe_o,
   // event outputs
   output logic             port_irq_flag_o,
   output logic             wake_o
);
   import ssp_pkg::*;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [3:0]   pin_in;          // raw pins
   logic [3:0]   s1_reg;          // first sync stage
   logic [3:0]   s2_reg;          // second sync stage
   logic [3:0]   p_reg;           // previous synced value
   logic         done_reg;        // bus answer cycle
   logic [31:0]  rdata_reg;       // bus read data
   logic [7:0]   ctrl_reg;        // control register
   logic [6:0]   own_reg;         // own bus address
   logic [7:0]   buf_reg;         // shared data buffer
   logic         bf_reg;          // buffer full
   logic         irq_reg;         // port irq flag
   logic         wcol_reg;        // write collision
   logic         arb_reg;         // arbitration lost
   logic         ovf_reg;         // receive overflow
   logic         tx_pend_reg;     // transmit byte waiting
   logic [7:0]   shift_reg;       // port shift register
   logic [3:0]   bitcnt_reg;      // bits shifted
   logic         spi_busy_reg;    // master transfer active
   logic         sck_m_reg;       // master serial clock
   logic         sdo_reg;         // serial data out
   logic [7:0]   div_reg;         // master clock divider
   logic         rx_evt_reg;      // byte received pulse
   logic [7:0]   rx_byte_reg;     // byte received
   logic         tx_evt_reg;      // byte sent pulse
   logic         tx_take_reg;     // buffer taken for send
   logic         arb_evt_reg;     // arbitration lost pulse
   logic         rw_reg;          // direction bit
   logic         sda_oe_reg;      // pull data low
   logic         scl_oe_reg;      // pull clock low (stretch)
   ssp_i2c_type  i2c_st;          // two-wire state
   ssp_mode_type mode;            // selected mode
   logic         en;              // port enabled
   logic         req;             // bus request present
   logic         wr_go;           // write completes
   logic         rd_go;           // read completes
   logic         wr_buf;          // buffer written
   logic         rd_buf;          // buffer read
   logic         tick;            // master half-period enable
   logic         spi_rise;        // serial clock rising
   logic         spi_fall;        // serial clock falling
   logic         scl_s;           // synced bus clock
   logic         sda_s;           // synced bus data
   logic         scl_r;           // bus clock rising
   logic         scl_f;           // bus clock falling
   logic         i2c_start;       // start condition seen
   logic         i2c_stop;        // stop condition seen
   logic         xfer_busy;       // buffer write not allowed
   logic [7:0]   stat;            // status byte

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   assign pin_in = {bus_data_line_i, bus_clock_line_i, sdi_i, serial_clock_pin_i};

   // two flops per pin, third flop only for edge finding
   generate
      for (genvar g = 0; g < 4; g++) begin : g_sync
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               s1_reg[g] <= 1'b1;
               s2_reg[g] <= 1'b1;
               p_reg[g]  <= 1'b1;
            end else begin
               s1_reg[g] <= pin_in[g];
               s2_reg[g] <= s1_reg[g];
               p_reg[g]  <= s2_reg[g];
            end
         end
      end
   endgenerate

   assign scl_s     = s2_reg[2];
   assign sda_s     = s2_reg[3];
   assign scl_r     = scl_s & ~p_reg[2];
   assign scl_f     = ~scl_s & p_reg[2];
   assign i2c_start = scl_s & p_reg[2] & ~sda_s & p_reg[3];
   assign i2c_stop  = scl_s & p_reg[2] & sda_s & ~p_reg[3];

   // ---------------------------------------------------------------
   // avalon-mm slave: one wait cycle, then answer
   // ---------------------------------------------------------------
   assign req           = read_i | write_i;
   assign waitrequest_o = req & ~done_reg;
   assign wr_go         = write_i & done_reg;
   assign rd_go         = read_i & done_reg;
   assign wr_buf        = wr_go & (address_i == OFS_BUF);
   assign rd_buf        = rd_go & (address_i == OFS_BUF);
   assign readdata_o    = rdata_reg;
   assign mode          = ssp_mode_type'(ctrl_reg[CTRL_MODE+:2]);
   assign en            = ctrl_reg[CTRL_EN];

   // status byte, top bit unused
   always_comb begin
      stat          = 8'h00;
      stat[ST_BF]   = bf_reg;
      stat[ST_IF]   = irq_reg;
      stat[ST_WCOL] = wcol_reg;
      stat[ST_ARB]  = arb_reg;
      stat[ST_RW]   = rw_reg;
      stat[ST_OVF]  = ovf_reg;
      stat[ST_BUSY] = xfer_busy;
   end

   // answer cycle flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= req & ~done_reg;
      end
   end

   // read mux captured in the wait cycle; unused bits are zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (read_i & ~done_reg) begin
         case (address_i)
            OFS_BUF:  rdata_reg <= {24'h00_0000, buf_reg};
            OFS_CTRL: rdata_reg <= {24'h00_0000, ctrl_reg};
            OFS_STAT: rdata_reg <= {24'h00_0000, stat};
            OFS_ADDR: rdata_reg <= {25'h000_0000, own_reg};
            default:  rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // control and address registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= CTRL_RST;
         own_reg  <= ADDR_RST;
      end else if (wr_go) begin
         if (address_i == OFS_CTRL) begin
            ctrl_reg <= {4'h0, writedata_i[3:0]};
         end
         if (address_i == OFS_ADDR) begin
            own_reg <= writedata_i[6:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // flags and the shared buffer
   // ---------------------------------------------------------------
   assign xfer_busy = (mode == MODE_I2C_SLV) ? (i2c_st == I2C_TX || i2c_st == I2C_TACK)
                                             : (spi_busy_reg || bitcnt_reg != 4'h0);

   // clears first, hardware sets last so a set wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         buf_reg     <= 8'h00;
         bf_reg      <= 1'b0;
         irq_reg     <= 1'b0;
         wcol_reg    <= 1'b0;
         arb_reg     <= 1'b0;
         ovf_reg     <= 1'b0;
         tx_pend_reg <= 1'b0;
      end else begin
         if (wr_buf) begin
            if (xfer_busy) begin
               wcol_reg <= 1'b1;       // write during transfer ignored
            end else begin
               buf_reg     <= writedata_i[7:0];
               tx_pend_reg <= 1'b1;
            end
         end
         if (rd_buf) begin
            bf_reg <= 1'b0;
         end
         if (tx_take_reg) begin
            tx_pend_reg <= 1'b0;
         end
         if (wr_go && address_i == OFS_STAT) begin
            irq_reg  <= irq_reg & ~writedata_i[ST_IF];
            wcol_reg <= wcol_reg & ~writedata_i[ST_WCOL];
            arb_reg  <= arb_reg & ~writedata_i[ST_ARB];
            ovf_reg  <= ovf_reg & ~writedata_i[ST_OVF];
         end
         if (rx_evt_reg) begin
            irq_reg <= 1'b1;
            if (bf_reg && !rd_buf) begin
               ovf_reg <= 1'b1;        // unread byte kept
            end else begin
               buf_reg <= rx_byte_reg;
               bf_reg  <= 1'b1;
            end
         end
         if (tx_evt_reg) begin
            irq_reg <= 1'b1;
         end
         if (arb_evt_reg) begin
            arb_reg <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // spi master clock divider, halted in sleep
   // ---------------------------------------------------------------
   assign tick = (div_reg == SPI_DIV - 8'h01) & ~sleep_i;

   // divider counts only while awake
   always_ff @(posedge clk_i) begin
      // a fresh load restarts the divider, so the first bit gets a full half period
      if (rst_i || !en || mode != MODE_SPI_MST || (wr_buf && !xfer_busy)) begin
         div_reg <= 8'h00;
      end else if (!sleep_i) begin
         div_reg <= tick ? 8'h00 : div_reg + 8'h01;
      end
   end

   // slave edges come from the pin only, master edges from the divider
   assign spi_rise = (mode == MODE_SPI_MST) ? (tick & ~sck_m_reg & spi_busy_reg)
                                            : (s2_reg[0] & ~p_reg[0]);
   assign spi_fall = (mode == MODE_SPI_MST) ? (tick & sck_m_reg)
                                            : (~s2_reg[0] & p_reg[0]);

   // ---------------------------------------------------------------
   // transfer engine: spi shifting and two-wire slave
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      rx_evt_reg  <= 1'b0;
      tx_evt_reg  <= 1'b0;
      tx_take_reg <= 1'b0;
      arb_evt_reg <= 1'b0;
      if (rst_i || !en || mode == MODE_OFF) begin
         shift_reg    <= 8'h00;
         bitcnt_reg   <= 4'h0;
         spi_busy_reg <= 1'b0;
         sck_m_reg    <= 1'b0;
         sdo_reg      <= 1'b0;
         rx_byte_reg  <= 8'h00;
         rw_reg       <= 1'b0;
         sda_oe_reg   <= 1'b0;
         scl_oe_reg   <= 1'b0;
         i2c_st       <= I2C_IDLE;
      end else if (mode != MODE_I2C_SLV) begin
         // spi: load on buffer write when idle
         if (wr_buf && !xfer_busy) begin
            shift_reg   <= writedata_i[7:0];
            sdo_reg     <= writedata_i[7];
            spi_busy_reg <= (mode == MODE_SPI_MST);
         end
         if (tick && (spi_busy_reg || sck_m_reg)) begin
            sck_m_reg <= ~sck_m_reg;
         end
         if (spi_rise) begin
            shift_reg <= {shift_reg[6:0], s2_reg[1]};
            if (bitcnt_reg == BYTE_BITS - 4'h1) begin
               bitcnt_reg   <= 4'h0;
               spi_busy_reg <= 1'b0;
               rx_evt_reg   <= 1'b1;
               rx_byte_reg  <= {shift_reg[6:0], s2_reg[1]};
            end else begin
               bitcnt_reg <= bitcnt_reg + 4'h1;
            end
         end
         if (spi_fall) begin
            sdo_reg <= shift_reg[7];
         end
      end else if (i2c_start) begin
         // start or repeated start opens address phase
         i2c_st     <= I2C_ADDR;
         bitcnt_reg <= 4'h0;
         sda_oe_reg <= 1'b0;
         scl_oe_reg <= 1'b0;
      end else if (i2c_stop) begin
         i2c_st     <= I2C_IDLE;
         sda_oe_reg <= 1'b0;
         scl_oe_reg <= 1'b0;
      end else begin
         case (i2c_st)
            I2C_ADDR, I2C_RX: begin
               if (scl_r) begin
                  shift_reg  <= {shift_reg[6:0], sda_s};
                  bitcnt_reg <= bitcnt_reg + 4'h1;
               end else if (scl_f && bitcnt_reg == BYTE_BITS) begin
                  bitcnt_reg <= 4'h0;
                  if (i2c_st == I2C_RX) begin
                     rx_evt_reg  <= 1'b1;
                     rx_byte_reg <= shift_reg;
                     sda_oe_reg  <= 1'b1;
                     i2c_st      <= I2C_ACK;
                  end else if (shift_reg[7:1] == own_reg) begin
                     rw_reg     <= shift_reg[0];
                     sda_oe_reg <= 1'b1;
                     i2c_st     <= I2C_ACK;
                  end else begin
                     i2c_st <= I2C_IDLE;
                  end
               end
            end
            I2C_ACK: begin
               if (scl_f) begin
                  sda_oe_reg <= 1'b0;
                  if (rw_reg) begin
                     scl_oe_reg <= 1'b1;
                     i2c_st     <= I2C_STR;
                  end else begin
                     i2c_st <= I2C_RX;
                  end
               end
            end
            I2C_STR: begin
               // hold clock low until software supplies a byte
               if (tx_pend_reg) begin
                  shift_reg   <= buf_reg;
                  sda_oe_reg  <= ~buf_reg[7];
                  tx_take_reg <= 1'b1;
                  i2c_st      <= I2C_TX;
               end
            end
            I2C_TX: begin
               // clock goes free only once the first bit already stands
               scl_oe_reg <= 1'b0;
               if (scl_r) begin
                  if (!sda_oe_reg && !sda_s) begin
                     arb_evt_reg <= 1'b1;
                     i2c_st      <= I2C_IDLE;
                  end else begin
                     bitcnt_reg <= bitcnt_reg + 4'h1;
                  end
               end else if (scl_f) begin
                  if (bitcnt_reg == BYTE_BITS) begin
                     bitcnt_reg <= 4'h0;
                     sda_oe_reg <= 1'b0;
                     i2c_st     <= I2C_TACK;
                  end else begin
                     sda_oe_reg <= ~shift_reg[6];
                     shift_reg  <= {shift_reg[6:0], 1'b0};
                  end
               end
            end
            I2C_TACK: begin
               if (scl_r) begin
                  tx_evt_reg <= 1'b1;
                  if (sda_s) begin
                     i2c_st <= I2C_IDLE;
                  end
               end else if (scl_f) begin
                  scl_oe_reg <= 1'b1;
                  i2c_st     <= I2C_STR;
               end
            end
            default: begin
               bitcnt_reg <= 4'h0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // pin and event outputs
   // ---------------------------------------------------------------
   assign serial_clock_pin_o    = sck_m_reg;
   assign serial_clock_pin_oe_o = en & (mode == MODE_SPI_MST);
   assign sdo_o                 = sdo_reg;
   assign bus_clock_line_o      = 1'b0;
   assign bus_data_line_o       = 1'b0;
   assign bus_clock_line_oe_o   = scl_oe_reg;
   assign bus_data_line_oe_o    = sda_oe_reg;
   assign port_irq_flag_o       = irq_reg;
   assign wake_o                = irq_reg & ctrl_reg[CTRL_IE];

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_answer;
      waitrequest_o ##1 !waitrequest_o;
   endsequence

   a_bus_answer: assert property (req && !done_reg |-> s_answer)
      else $error("bus answer late");
   a_sleep_freeze: assert property (sleep_i |=> sck_m_reg == $past(sck_m_reg))
      else $error("master clock moved in sleep");
   a_byte_flags: assert property (rx_evt_reg |=> irq_reg && (bf_reg || ovf_reg))
      else $error("byte did not set flags");
   a_wake_follow: assert property (rx_evt_reg && ctrl_reg[CTRL_IE] |=> wake_o)
      else $error("no wake after byte");
   a_reserved_zero: assert property (rd_go |-> readdata_o[31:8] == 24'h00_0000)
      else $error("reserved bits not zero");
   a_buf_clear: assert property (rd_buf && !rx_evt_reg |=> !bf_reg)
      else $error("buffer read left full");
   a_data_steady: assert property (mode == MODE_I2C_SLV && en && $changed(sda_oe_reg)
                                   |-> !scl_s)
      else $error("data moved with clock high");
   a_arb_release: assert property ($rose(arb_reg) |-> i2c_st == I2C_IDLE && !sda_oe_reg)
      else $error("bus kept after lost arbitration");
   a_ack_drive: assert property (i2c_st == I2C_ACK |-> sda_oe_reg)
      else $error("acknowledge not driven");
   a_stretch_hold: assert property (i2c_st == I2C_STR |-> scl_oe_reg)
      else $error("clock not held while waiting");
endmodule

// ### ssp_bus_master.sv
// two-wire bus master model for the port's far side
`timescale 1ns/1ps
module ssp_bus_master (
   // clock and line levels
   input  wire logic clk_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   // pull-down enables, released at rest
   output logic      scl_pull_o = 1'b0,
   output logic      sda_pull_o = 1'b0
);
   // quarter bit, keeps edges well apart
   task automatic q();
      repeat (4) @(posedge clk_i);
   endtask
   // one bit: change while low, sample on rise, wait out a stretch
   task automatic bit_io(input logic b, output logic s);
      sda_pull_o <= ~b;
      q();
      scl_pull_o <= 1'b0;
      for (int n = 0; n < 3000 && scl_i !== 1'b1; n++) @(posedge clk_i);
      s = sda_i;
      q();
      q();
      scl_pull_o <= 1'b1;
      q();
   endtask
   // start or repeated start: data falls while clock high
   task automatic start();
      sda_pull_o <= 1'b0;
      q();
      scl_pull_o <= 1'b0;
      q();
      sda_pull_o <= 1'b1;
      q();
      scl_pull_o <= 1'b1;
      q();
   endtask
   // stop: data rises while clock high
   task automatic stop();
      sda_pull_o <= 1'b1;
      q();
      scl_pull_o <= 1'b0;
      q();
      sda_pull_o <= 1'b0;
      q();
   endtask
   // byte out msb first; r holds the levels seen, ack the ninth slot
   task automatic send(input logic [7:0] d, output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(1'b1, ack);
   endtask
endmodule

// ### tb_ssp_port.sv
// self-checking bench for the sync serial port
`timescale 1ns/1ps
module tb_ssp_port;
   import ssp_pkg::*;
   logic        clk_i, rst_i, read_i, write_i, sleep_i, sck, sdi, ack, irq;
   logic        sdo, sck_o, sck_oe, k, loop;
   logic [3:0]  address_i;
   logic [31:0] writedata_i, readdata_o, exp_q[$];
   logic        waitrequest_o, scl_oe, sda_oe, m_scl, m_sda, wake;
   logic [7:0]  d, r;
   int          bad_count = 0, comparisons = 0, cyc = 0;
   wire         scl = ~(scl_oe | m_scl); // pulled-up open-drain lines
   wire         sda = ~(sda_oe | m_sda);
   wire         sdi_w = loop ? sdo : sdi; // spi master loopback
   ssp_port u_dut (.clk_i, .rst_i, .address_i, .read_i, .write_i, .writedata_i,
      .readdata_o, .waitrequest_o, .sleep_i, .serial_clock_pin_i(sck),
      .serial_clock_pin_o(sck_o), .serial_clock_pin_oe_o(sck_oe), .sdi_i(sdi_w), .sdo_o(sdo),
      .bus_clock_line_i(scl), .bus_clock_line_o(), .bus_clock_line_oe_o(scl_oe),
      .bus_data_line_i(sda), .bus_data_line_o(), .bus_data_line_oe_o(sda_oe),
      .port_irq_flag_o(irq), .wake_o(wake));
   ssp_bus_master u_bus (.clk_i, .scl_i(scl), .sda_i(sda), .scl_pull_o(m_scl),
      .sda_pull_o(m_sda));
   // system clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // verdict and end of run
   task automatic test_done();
      if (bad_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // compare a single-bit result
   task automatic check_bit(input string n, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask
   // compare a word result
   task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] v);
      read_i <= ~wr;
      write_i <= wr;
      address_i <= a;
      writedata_i <= v;
      do @(posedge clk_i); while (waitrequest_o !== 1'b0);
      read_i <= 1'b0;
      write_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // read with expected word noted for the monitor
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   // monitor takes read data where the answer stands, plus timeout
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (read_i && waitrequest_o === 1'b0) begin
         check_word("readdata", exp_q.pop_front(), readdata_o);
      end
      if (cyc == 20000) begin
         bad_count++;
         test_done();
      end
   end
   // main sequence
   initial begin
      rst_i <= 1'b1;
      {read_i, write_i, sleep_i, sck, sdi, loop} <= 6'h00;
      address_i <= 4'h0;
      writedata_i <= 32'h0000_0000;
      void'($urandom(63173));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(OFS_CTRL, {24'h0, CTRL_RST});
      rd(OFS_ADDR, {25'h0, ADDR_RST});
      rd(4'h2, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h0000_000D);
      d = $urandom;
      u_bus.start();
      u_bus.send({ADDR_RST, 1'b0}, r, ack);
      check_bit("address ack", 1'b0, ack);
      u_bus.send(d, r, ack);
      check_bit("data ack", 1'b0, ack);
      u_bus.start();
      u_bus.send({ADDR_RST ^ 7'h01, 1'b0}, r, ack);
      check_bit("foreign ack", 1'b1, ack);
      u_bus.stop();
      rd(OFS_STAT, 32'h03);
      check_bit("wake", 1'b1, wake);
      rd(OFS_BUF, {24'h0, d});
      rd(OFS_STAT, 32'h02);
      bus(1'b1, OFS_STAT, 32'h02);
      check_bit("wake", 1'b0, wake);
      d = $urandom;
      u_bus.start();
      u_bus.send({ADDR_RST, 1'b1}, r, ack);
      check_bit("read ack", 1'b0, ack);
      fork
         u_bus.send(8'hFF, r, ack);
         begin
            repeat (200) @(posedge clk_i);
            check_bit("stretch", 1'b0, scl);
            bus(1'b1, OFS_BUF, {24'h0, d});
         end
      join
      u_bus.stop();
      check_word("read byte", {24'h0, d}, {24'h0, r});
      rd(OFS_STAT, 32'h12);
      d[7] = 1'b1;
      bus(1'b1, OFS_BUF, {24'h0, d});
      u_bus.start();
      u_bus.send({ADDR_RST, 1'b1}, r, ack);
      u_bus.send(8'h7F, r, ack);
      u_bus.stop();
      rd(OFS_STAT, 32'h1A);
      bus(1'b1, OFS_STAT, 32'h0A);
      bus(1'b1, OFS_CTRL, 32'h0000_000B);
      sleep_i <= 1'b1;
      d = $urandom;
      for (int i = 7; i >= 0; i--) begin
         sdi <= d[i];
         repeat (6) @(posedge clk_i);
         sck <= 1'b1;
         repeat (6) @(posedge clk_i);
         sck <= 1'b0;
      end
      repeat (12) @(posedge clk_i);
      check_bit("irq", 1'b1, irq);
      check_bit("wake", 1'b1, wake);
      sleep_i <= 1'b0;
      rd(OFS_BUF, {24'h0, d});
      bus(1'b1, OFS_STAT, 32'h02);
      bus(1'b1, OFS_CTRL, 32'h09);
      loop <= 1'b1;
      d = $urandom;
      bus(1'b1, OFS_BUF, {24'h0, d});
      repeat (10) @(posedge clk_i);
      sleep_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      k = sck_o;
      repeat (100) @(posedge clk_i);
      check_bit("frozen clock", k, sck_o);
      check_bit("frozen irq", 1'b0, irq);
      sleep_i <= 1'b0;
      repeat (100) @(posedge clk_i);
      check_bit("clock drive", 1'b1, sck_oe);
      check_bit("master irq", 1'b1, irq);
      rd(OFS_BUF, {24'h0, d});
      bus(1'b1, OFS_CTRL, 32'h07);
      rd(OFS_STAT, 32'h02);
      test_done();
   end
endmodule
